// >>> logic/snp_pkg.sv
/*
  shared constants, types and the instruction encoder of the serial
  programming host.
  assumes a 20 MHz core clock and a target that is driven through its
  reset, serial clock, serial data in and serial data out pins.
*/
package snp_pkg;

  // core clock rate
  localparam int unsigned CLK_MHZ = 20;

  // link timing, figures in their own units
  localparam int unsigned POWERUP_US     = 20_000; // wait before enable
  localparam int unsigned FLASH_WRITE_US = 16_000; // flash_write_time
  localparam int unsigned EEPROM_WRITE_US = 4_000; // eeprom_write_time
  localparam int unsigned RST_PULSE_NS   = 1_000;  // reset high pulse
  localparam int unsigned SCK_HALF_NS    = 200;    // each sck phase

  // cycle counts derived from the times; least times round up
  localparam int unsigned POWERUP_CYC  = POWERUP_US * CLK_MHZ;
  localparam int unsigned FLASH_CYC    = FLASH_WRITE_US * CLK_MHZ;
  localparam int unsigned EEPROM_CYC   = EEPROM_WRITE_US * CLK_MHZ;
  localparam int unsigned RST_PULSE_CYC =
    (RST_PULSE_NS * CLK_MHZ + 999) / 1000;
  localparam int unsigned SCK_HALF_CYC =
    (SCK_HALF_NS * CLK_MHZ + 999) / 1000;

  // wait counter width, holds twice the flash write time
  localparam int unsigned WAIT_W = 21;

  // enable handshake
  localparam int unsigned ENABLE_TRIES = 32;
  localparam logic [7:0]  ECHO_BYTE    = 8'h53;

  // instruction bytes
  localparam logic [7:0] OP_ENABLE   = 8'hAC;
  localparam logic [7:0] ERASE_B2    = 8'h80;
  localparam logic [7:0] OP_READ_PM  = 8'h20;
  localparam logic [7:0] OP_LOAD_PG  = 8'h40;
  localparam logic [7:0] OP_WRITE_PG = 8'h4C;
  localparam logic [7:0] OP_READ_EE  = 8'hA0;
  localparam logic [7:0] OP_WRITE_EE = 8'hC0;
  localparam logic [7:0] LOAD_FILL   = 8'hFF;
  localparam int unsigned HIGH_BIT   = 3;  // high byte select in byte 1
  localparam int unsigned INSTR_BITS = 32;
  localparam logic [4:0] LAST_BIT    = 5'h1F;

  // user command kinds
  typedef enum logic [2:0] {
    CMD_ERASE,
    CMD_LOAD,
    CMD_WRITE_PAGE,
    CMD_READ_PM,
    CMD_WRITE_EE,
    CMD_READ_EE,
    CMD_END
  } snp_op_t;

  // one queued command
  typedef struct packed {
    snp_op_t     op;
    logic        high;   // program memory high byte
    logic [13:0] addr;   // word address or eeprom address
    logic [7:0]  data;
  } snp_cmd_t;

  localparam int unsigned CMD_W = $bits(snp_cmd_t);

  // builds the four byte instruction, first byte in the top bits
  function automatic logic [31:0] snp_encode(input snp_cmd_t c);
    logic [7:0] hop;
    hop = 8'h00;
    hop[HIGH_BIT] = c.high;
    unique case (c.op)
      CMD_ERASE:      return {OP_ENABLE, ERASE_B2, 16'h0000};
      CMD_LOAD:       return {OP_LOAD_PG | hop, 8'h00,
                              2'b00, c.addr[5:0], c.data};
      CMD_WRITE_PAGE: return {OP_WRITE_PG, 2'b00, c.addr[13:8],
                              c.addr[7:6], 6'h00, 8'h00};
      CMD_READ_PM:    return {OP_READ_PM | hop, 2'b00, c.addr[13:8],
                              c.addr[7:0], 8'h00};
      CMD_WRITE_EE:   return {OP_WRITE_EE, 6'h00, c.addr[9:8],
                              c.addr[7:0], c.data};
      CMD_READ_EE:    return {OP_READ_EE, 6'h00, c.addr[9:8],
                              c.addr[7:0], 8'h00};
      default:        return {OP_ENABLE, ECHO_BYTE, 16'h0000};
    endcase
  endfunction

endpackage

// >>> logic/snp_div.sv
/*
  free running divider that gives a one cycle tick every HALF cycles.
  assumes one clock and an asynchronous active low reset.
*/
`timescale 1ns/1ns
module snp_div
  import snp_pkg::*;
#(
  parameter int unsigned HALF = 8
) (
  input  wire logic core_clk_i,
  input  wire logic rstn_i,
  output logic      tick_o
);

  logic [7:0] cnt_reg;  // cycles left in this phase

  // count down and pulse at zero
  always_ff @(posedge core_clk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      cnt_reg <= 8'h00;
      tick_o  <= 1'b0;
    end else if (cnt_reg == 8'h00) begin
      cnt_reg <= 8'(HALF - 1);
      tick_o  <= 1'b1;
    end else begin
      cnt_reg <= cnt_reg - 8'h01;
      tick_o  <= 1'b0;
    end
  end

endmodule

// >>> logic/snp_fifo.sv
/*
  small first in first out buffer with valid and ready on both sides.
  assumes one clock and an asynchronous active low reset.
*/
`timescale 1ns/1ns
module snp_fifo #(
  parameter int unsigned WIDTH = 8,
  parameter int unsigned DEPTH = 4
) (
  input  wire logic             core_clk_i,
  input  wire logic             rstn_i,
  input  wire logic             in_valid_i,
  output logic                  in_ready_o,
  input  wire logic [WIDTH-1:0] in_data_i,
  output logic                  out_valid_o,
  input  wire logic             out_ready_i,
  output logic      [WIDTH-1:0] out_data_o
);

  localparam int unsigned AW = $clog2(DEPTH);

  logic [WIDTH-1:0] mem [DEPTH];  // storage
  logic [AW-1:0]    wr_reg;       // write pointer
  logic [AW-1:0]    rd_reg;       // read pointer
  logic [AW:0]      cnt_reg;      // words held
  logic             push;
  logic             pop;

  assign push        = in_valid_i && in_ready_o;
  assign pop         = out_valid_o && out_ready_i;
  assign out_data_o  = mem[rd_reg];

  // storage write
  always_ff @(posedge core_clk_i) begin
    if (push) begin
      mem[wr_reg] <= in_data_i;
    end
  end

  // pointers, count and registered full and empty flags
  always_ff @(posedge core_clk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      wr_reg      <= '0;
      rd_reg      <= '0;
      cnt_reg     <= '0;
      in_ready_o  <= 1'b1;
      out_valid_o <= 1'b0;
    end else begin
      if (push) begin
        wr_reg <= (wr_reg == AW'(DEPTH - 1)) ? '0 : wr_reg + 1'b1;
      end
      if (pop) begin
        rd_reg <= (rd_reg == AW'(DEPTH - 1)) ? '0 : rd_reg + 1'b1;
      end
      if (push && !pop) begin
        cnt_reg     <= cnt_reg + 1'b1;
        in_ready_o  <= (cnt_reg != (AW+1)'(DEPTH - 1));
        out_valid_o <= 1'b1;
      end else if (pop && !push) begin
        cnt_reg     <= cnt_reg - 1'b1;
        in_ready_o  <= 1'b1;
        out_valid_o <= (cnt_reg != (AW+1)'(1));
      end
    end
  end

endmodule

// >>> logic/snp_host.sv
/*
  serial programming host: powers the target into programming mode,
  synchronises with the enable instruction and runs queued commands.
  assumes the target pins are wired straight to the ports, the serial
  data return from the target is asynchronous, and commands arrive on
  the same clock.
*/
`timescale 1ns/1ns
module snp_host
  import snp_pkg::*;
#(
  parameter int unsigned POWERUP_CYCLES = POWERUP_CYC,
  parameter int unsigned FLASH_CYCLES   = FLASH_CYC,
  parameter int unsigned EEPROM_CYCLES  = EEPROM_CYC
) (
  input  wire logic       core_clk_i,
  input  wire logic       rstn_i,
  input  wire logic       cmd_valid_i,
  output logic            cmd_ready_o,
  input  wire snp_cmd_t   cmd_i,
  output logic            rsp_valid_o,
  output logic [7:0]      rsp_data_o,
  output logic            dev_rst_n_o,
  output logic            sck_o,
  output logic            mosi_o,
  input  wire logic       miso_i,
  output logic            in_prog_o,
  output logic            no_device_o
);

  typedef enum {
    ST_POWERUP,
    ST_ENABLE,
    ST_RETRY,
    ST_IDLE,
    ST_SEND,
    ST_WAIT,
    ST_RST_PULSE,
    ST_ENDED,
    ST_NODEV
  } snp_state_t;

  snp_state_t        state_reg;   // sequencer state
  logic              tick;        // sck phase tick
  logic              q_valid;     // queued command present
  logic              q_pop;       // take queued command
  snp_cmd_t          q_cmd;       // head of queue
  snp_cmd_t          cur_reg;     // command on the link
  logic              miso_s1;     // synchroniser first stage
  logic              miso_s2;     // synchronised serial return
  logic [31:0]       sh_word;     // instruction about to load
  logic              lead_reg;    // setup phase before the first rise
  logic [31:0]       tx_reg;      // bits still to send
  logic [31:0]       rx_reg;      // bits received
  logic [4:0]        bit_reg;     // bit index in instruction
  logic              sh_go;       // start a shift
  logic              sh_busy_reg; // shift in progress
  logic              sh_done_reg; // one cycle, shift finished
  logic              pulse_done;  // retry sck pulse finished
  logic [WAIT_W-1:0] wait_reg;    // wait countdown
  logic [5:0]        try_reg;     // enable attempts made
  logic              echo_ok;     // echo seen in third byte
  logic              after_erase_reg; // wait ends in a reset pulse

  // sck phase timing keeps both phases well over two target cycles
  snp_div #(
    .HALF (SCK_HALF_CYC)
  ) u_div (
    .core_clk_i (core_clk_i),
    .rstn_i     (rstn_i),
    .tick_o     (tick)
  );

  // command queue between the user and the link
  snp_fifo #(
    .WIDTH (CMD_W),
    .DEPTH (4)
  ) u_fifo (
    .core_clk_i  (core_clk_i),
    .rstn_i      (rstn_i),
    .in_valid_i  (cmd_valid_i),
    .in_ready_o  (cmd_ready_o),
    .in_data_i   (cmd_i),
    .out_valid_o (q_valid),
    .out_ready_i (q_pop),
    .out_data_o  (q_cmd)
  );

  // the target echo arrives in the third byte
  assign echo_ok = (rx_reg[15:8] == ECHO_BYTE);

  // pop only when the link is free to run it
  assign q_pop = (state_reg == ST_IDLE) && q_valid
               && !sh_busy_reg && !sh_done_reg;

  // start a shift on a popped command other than end; enable shifts start from power-up
  assign sh_go = q_pop && (q_cmd.op != CMD_END);

  // word to shift: a popped command or the enable instruction
  assign sh_word = sh_go ? snp_encode(q_cmd)
                         : {OP_ENABLE, ECHO_BYTE, 16'h0000};

  // retry pulse ends when sck falls back low
  assign pulse_done = (state_reg == ST_RETRY) && tick && sck_o;

  // two flop synchroniser for the serial return
  always_ff @(posedge core_clk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      miso_s1 <= 1'b0;
      miso_s2 <= 1'b0;
    end else begin
      miso_s1 <= miso_i;
      miso_s2 <= miso_s1;
    end
  end

  // shifter: data set while sck low, sck rises for the target to
  // sample, return sampled just before sck falls
  always_ff @(posedge core_clk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      sck_o       <= 1'b0;
      mosi_o      <= 1'b0;
      tx_reg      <= 32'h0000_0000;
      rx_reg      <= 32'h0000_0000;
      bit_reg     <= 5'h00;
      lead_reg    <= 1'b0;
      sh_busy_reg <= 1'b0;
      sh_done_reg <= 1'b0;
    end else begin
      sh_done_reg <= 1'b0;
      if (sh_go || (state_reg == ST_POWERUP && wait_reg == '0
                    && !sh_busy_reg)) begin
        // msb first over all 32 bits, first bit out at once
        mosi_o      <= sh_word[INSTR_BITS-1];
        tx_reg      <= {sh_word[30:0], 1'b0};
        bit_reg     <= 5'h00;
        lead_reg    <= 1'b1;
        sh_busy_reg <= 1'b1;
      end else if (sh_busy_reg && tick) begin
        if (!sck_o && lead_reg) begin
          // first bit gets a full phase of setup before the rise
          lead_reg <= 1'b0;
        end else if (!sck_o) begin
          // data has stood a full phase before the rise
          sck_o <= 1'b1;
        end else begin
          // target moves its output on this fall
          rx_reg <= {rx_reg[30:0], miso_s2};
          sck_o  <= 1'b0;
          if (bit_reg == LAST_BIT) begin
            sh_busy_reg <= 1'b0;
            sh_done_reg <= 1'b1;
          end else begin
            // next bit is set while sck is low
            mosi_o  <= tx_reg[INSTR_BITS-1];
            tx_reg  <= {tx_reg[30:0], 1'b0};
            bit_reg <= bit_reg + 5'h01;
          end
        end
      end else if (state_reg == ST_RETRY && tick) begin
        // single positive sck pulse to slip one bit
        sck_o <= !sck_o;
      end
    end
  end

  // sequencer
  always_ff @(posedge core_clk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      state_reg       <= ST_POWERUP;
      dev_rst_n_o     <= 1'b0;
      wait_reg        <= WAIT_W'(POWERUP_CYCLES);
      try_reg         <= 6'h00;
      cur_reg         <= '0;
      after_erase_reg <= 1'b0;
      in_prog_o       <= 1'b0;
      no_device_o     <= 1'b0;
    end else begin
      unique case (state_reg)
        ST_POWERUP: begin
          // target held in reset, sck low, settle before enable
          if (wait_reg != '0) begin
            wait_reg <= wait_reg - 1'b1;
          end else if (sh_busy_reg) begin
            state_reg <= ST_ENABLE;
            try_reg   <= try_reg + 6'h01;
          end
        end
        ST_ENABLE: begin
          // all four bytes go out whether or not the echo came
          if (sh_done_reg) begin
            if (echo_ok) begin
              state_reg <= ST_IDLE;
              in_prog_o <= 1'b1;
              try_reg   <= 6'h00;
            end else if (try_reg == 6'(ENABLE_TRIES)) begin
              state_reg   <= ST_NODEV;
              no_device_o <= 1'b1;
            end else begin
              state_reg <= ST_RETRY;
            end
          end
        end
        ST_RETRY: begin
          // after the slip pulse send enable again at once
          if (pulse_done) begin
            state_reg <= ST_POWERUP;
            wait_reg  <= '0;
          end
        end
        ST_IDLE: begin
          if (q_pop) begin
            cur_reg <= q_cmd;
            if (q_cmd.op == CMD_END) begin
              // releasing reset ends the session
              state_reg   <= ST_ENDED;
              dev_rst_n_o <= 1'b1;
              in_prog_o   <= 1'b0;
            end else begin
              state_reg <= ST_SEND;
            end
          end
        end
        ST_SEND: begin
          // pace each write by its worst case, no polling
          if (sh_done_reg) begin
            unique case (cur_reg.op)
              CMD_ERASE: begin
                state_reg       <= ST_WAIT;
                wait_reg        <= WAIT_W'(2 * FLASH_CYCLES);
                after_erase_reg <= 1'b1;
              end
              CMD_WRITE_PAGE: begin
                state_reg <= ST_WAIT;
                wait_reg  <= WAIT_W'(FLASH_CYCLES);
              end
              CMD_WRITE_EE: begin
                // target erases the byte itself inside the write
                state_reg <= ST_WAIT;
                wait_reg  <= WAIT_W'(EEPROM_CYCLES);
              end
              default: begin
                state_reg <= ST_IDLE;
              end
            endcase
          end
        end
        ST_WAIT: begin
          // no link access while the target is self-timed
          if (wait_reg != '0) begin
            wait_reg <= wait_reg - 1'b1;
          end else if (after_erase_reg) begin
            state_reg       <= ST_RST_PULSE;
            dev_rst_n_o     <= 1'b1;
            in_prog_o       <= 1'b0;
            wait_reg        <= WAIT_W'(RST_PULSE_CYC);
            after_erase_reg <= 1'b0;
          end else begin
            state_reg <= ST_IDLE;
          end
        end
        ST_RST_PULSE: begin
          // sck is low here, reset pulse then start over
          if (wait_reg != '0) begin
            wait_reg <= wait_reg - 1'b1;
          end else begin
            state_reg   <= ST_POWERUP;
            dev_rst_n_o <= 1'b0;
            wait_reg    <= WAIT_W'(POWERUP_CYCLES);
          end
        end
        ST_ENDED: begin
          // a new command opens a fresh session
          if (q_valid) begin
            state_reg   <= ST_POWERUP;
            dev_rst_n_o <= 1'b0;
            wait_reg    <= WAIT_W'(POWERUP_CYCLES);
            try_reg     <= 6'h00;
          end
        end
        ST_NODEV: begin
          // no target answered, hold the link quiet
          state_reg <= ST_NODEV;
        end
      endcase
    end
  end

  // read data is the fourth byte returned
  always_ff @(posedge core_clk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      rsp_valid_o <= 1'b0;
      rsp_data_o  <= 8'h00;
    end else begin
      rsp_valid_o <= 1'b0;
      if (state_reg == ST_SEND && sh_done_reg
          && (cur_reg.op == CMD_READ_PM
              || cur_reg.op == CMD_READ_EE)) begin
        rsp_valid_o <= 1'b1;
        rsp_data_o  <= rx_reg[7:0];
      end
    end
  end

endmodule

// >>> verification/snp_host_sva.sv
/*
  checker of the serial programming host, watching its ports only.
  assumes one clock domain and the bind at the foot of this file.
*/
`timescale 1ns/1ns
module snp_host_sva
  import snp_pkg::*;
#(
  parameter int unsigned POWERUP_CYCLES = POWERUP_CYC
) (
  input wire logic       core_clk_i,
  input wire logic       rstn_i,
  input wire logic       cmd_valid_i,
  input wire logic       cmd_ready_o,
  input wire snp_cmd_t   cmd_i,
  input wire logic       rsp_valid_o,
  input wire logic [7:0] rsp_data_o,
  input wire logic       dev_rst_n_o,
  input wire logic       sck_o,
  input wire logic       mosi_o,
  input wire logic       miso_i,
  input wire logic       in_prog_o,
  input wire logic       no_device_o
);
  default clocking cb @(posedge core_clk_i); endclocking
  default disable iff (!rstn_i);

  logic [31:0] low_cnt_reg; // cycles since target reset went low

  // counts how long the target has been held in reset
  always_ff @(posedge core_clk_i or negedge rstn_i) begin
    if (!rstn_i)
      low_cnt_reg <= 32'h0000_0000;
    else if (dev_rst_n_o)
      low_cnt_reg <= 32'h0000_0000;
    else if (low_cnt_reg != 32'hFFFF_FFFF)
      low_cnt_reg <= low_cnt_reg + 32'h0000_0001;
  end

  a_sck_high_width: assert property (
    $rose(sck_o) |-> sck_o [*4]) else $error("sck high phase short");
  a_sck_low_width: assert property (
    $fell(sck_o) |-> !sck_o [*4]) else $error("sck low phase short");
  a_mosi_steady: assert property (
    sck_o |-> $stable(mosi_o)) else $error("mosi moved with sck high");
  a_sck_gated: assert property (
    dev_rst_n_o |-> !sck_o) else $error("sck high with reset high");
  a_prog_in_reset: assert property (
    in_prog_o |-> !dev_rst_n_o) else $error("session with reset high");
  a_rsp_single: assert property (
    rsp_valid_o |=> !rsp_valid_o) else $error("read pulse too long");
  a_rsp_in_session: assert property (
    rsp_valid_o |-> in_prog_o && !sck_o) else $error("read outside session");
  a_nodev_sticky: assert property (
    no_device_o |=> no_device_o && !in_prog_o) else $error("no device lost");
  a_enable_wait: assert property (
    $rose(sck_o) |-> low_cnt_reg >= POWERUP_CYCLES)
    else $error("clocking before power-up wait");

  c_read: cover property (rsp_valid_o);
  c_nodev: cover property ($rose(no_device_o));
  c_full: cover property (!cmd_ready_o);
  c_release: cover property ($rose(dev_rst_n_o));
endmodule

bind snp_host snp_host_sva #(
  .POWERUP_CYCLES(POWERUP_CYCLES)
) snp_host_sva_inst (
  .core_clk_i(core_clk_i), .rstn_i(rstn_i), .cmd_valid_i(cmd_valid_i),
  .cmd_ready_o(cmd_ready_o), .cmd_i(cmd_i), .rsp_valid_o(rsp_valid_o),
  .rsp_data_o(rsp_data_o), .dev_rst_n_o(dev_rst_n_o), .sck_o(sck_o),
  .mosi_o(mosi_o), .miso_i(miso_i), .in_prog_o(in_prog_o),
  .no_device_o(no_device_o)
);

// >>> verification/snp_target_model.sv
/*
  behavioural model of the target's serial programming port.
  assumes the host drives reset, sck and mosi; times are shortened.
*/
`timescale 1ns/1ns
module snp_target_model #(
  parameter int RC_NS = 1 // shortened oscillator period
) (
  input  wire logic rst_n_i,
  input  wire logic sck_i,
  input  wire logic mosi_i,
  input  wire logic present_i,
  output logic      miso_o
);
  logic [7:0]  fl_mem [int];   // program bytes, key word*2+high
  logic [7:0]  ee_mem [int];   // eeprom bytes
  logic [7:0]  page_buf [int]; // loaded page bytes
  logic [31:0] rx_reg = '0;    // received bits
  logic [7:0]  out_reg = '0;   // byte being returned
  logic        on_reg = 1'b0;  // programming enabled
  logic        drv_reg = 1'b0; // bit on the data return
  int          bit_cnt = 0;
  int          busy_pg = -1;
  int          busy_ee = -1;
  time         fl_until = 0;
  time         ee_until = 0;

  // a released pin shows the inverse of its last bit
  assign miso_o = rst_n_i ? ~drv_reg : drv_reg;

  // read side: busy places read all ones
  function automatic logic [7:0] rd(input logic [23:0] w);
    int a;
    a = {w[13:8], w[7:0], w[19]};
    if (!on_reg)
      return 8'h00;
    if (w[23:16] == 8'hA0) begin
      a = {w[9:8], w[7:0]};
      if ($time < ee_until && a == busy_ee) return 8'hFF;
      return ee_mem.exists(a) ? ee_mem[a] : 8'hFF;
    end
    if ((w[23:16] & 8'hF7) != 8'h20) return 8'h00;
    if ($time < fl_until && (a >> 7) == busy_pg) return 8'hFF;
    return fl_mem.exists(a) ? fl_mem[a] : 8'hFF;
  endfunction

  // acts on a complete instruction
  task automatic run(input logic [31:0] w);
    int pg;
    pg = {w[21:16], w[15:14]};
    if (w[31:16] == 16'hAC53) begin
      on_reg = present_i;
    end else if (on_reg && w[31:24] == 8'hAC && w[23:21] == 3'b100) begin
      fl_mem.delete();
      ee_mem.delete();
    end else if (on_reg && (w[31:24] & 8'hF7) == 8'h40) begin
      page_buf[{w[13:8], w[27]}] = w[7:0];
    end else if (on_reg && w[31:24] == 8'h4C) begin
      foreach (page_buf[i]) fl_mem[pg * 128 + i] = page_buf[i];
      page_buf.delete();
      busy_pg = pg;
      fl_until = $time + 8192 * RC_NS;
    end else if (on_reg && w[31:24] == 8'hC0) begin
      busy_ee = {w[17:16], w[15:8]};
      ee_mem[busy_ee] = w[7:0];
      ee_until = $time + 2048 * RC_NS;
    end
  endtask

  // leaving reset ends the session
  always @(posedge rst_n_i) begin
    on_reg = 1'b0;
    bit_cnt = 0;
  end

  // takes a bit on each sck rise, msb first
  always @(posedge sck_i) begin
    if (!rst_n_i) begin
      rx_reg = {rx_reg[30:0], mosi_i};
      bit_cnt = bit_cnt + 1;
      if (bit_cnt == 32) begin
        bit_cnt = 0;
        run(rx_reg);
      end
    end
  end

  // gives the next bit on each sck fall
  always @(negedge sck_i) begin
    if (!rst_n_i) begin
      if (bit_cnt == 16)
        out_reg = (rx_reg[15:8] == 8'hAC && present_i) ? rx_reg[7:0]
                                                        : 8'h00;
      else if (bit_cnt == 24)
        out_reg = rd(rx_reg[23:0]);
      else if (bit_cnt % 8 == 0)
        out_reg = 8'h00;
      drv_reg = out_reg[7 - (bit_cnt % 8)];
    end
  end
endmodule

// >>> verification/test_snp_host.sv
/*
  self-checking bench of the serial programming host with a target model.
  assumes shortened wait parameters and a 20 MHz clock.
*/
`timescale 1ns/1ns
module test_snp_host
  import snp_pkg::*;
  ;
  logic       core_clk_i, rstn_i, cmd_valid_i, present;
  logic       cmd_ready_o, rsp_valid_o, dev_rst_n_o, sck_o, mosi_o, miso_i;
  logic       in_prog_o, no_device_o;
  logic [7:0] rsp_data_o;
  snp_cmd_t   cmd_i;
  logic [7:0] exp_q [$];     // expected read bytes, oldest first
  int         err_count = 0;
  int         n_compared = 0;
  int         cyc = 0;
  int         seed = 53;

  snp_host #(.POWERUP_CYCLES(50), .FLASH_CYCLES(200), .EEPROM_CYCLES(50))
  snp_host_inst (
    .core_clk_i(core_clk_i), .rstn_i(rstn_i), .cmd_valid_i(cmd_valid_i),
    .cmd_ready_o(cmd_ready_o), .cmd_i(cmd_i), .rsp_valid_o(rsp_valid_o),
    .rsp_data_o(rsp_data_o), .dev_rst_n_o(dev_rst_n_o), .sck_o(sck_o),
    .mosi_o(mosi_o), .miso_i(miso_i), .in_prog_o(in_prog_o),
    .no_device_o(no_device_o));

  snp_target_model snp_target_model_inst (
    .rst_n_i(dev_rst_n_o), .sck_i(sck_o), .mosi_i(mosi_o),
    .present_i(present), .miso_o(miso_i));

  initial begin
    core_clk_i = 1'b0;
    forever #25 core_clk_i = ~core_clk_i;
  end

  task automatic print_verdict();
    $display("compared %0d mismatches %0d", n_compared, err_count);
    if (err_count == 0 && n_compared > 0)
      $display("bench passed");
    else
      $display("bench failed");
    $finish;
  endtask

  task automatic cmp_byte(input string what, input logic [7:0] e,
                          input logic [7:0] g);
    n_compared++;
    if (g !== e) begin
      err_count++;
      $display("mismatch %s expected %h seen %h", what, e, g);
    end
  endtask

  task automatic cmp_flag(input string what, input logic e, input logic g);
    n_compared++;
    if (g !== e) begin
      err_count++;
      $display("mismatch %s expected %b seen %b", what, e, g);
    end
  endtask

  function automatic snp_cmd_t mk(input snp_op_t op, input logic hi,
                                  input logic [13:0] a, input logic [7:0] d);
    return '{op: op, high: hi, addr: a, data: d};
  endfunction

  // offers one command and holds it until taken
  task automatic send(input snp_cmd_t x);
    int k;
    k = 0;
    @(posedge core_clk_i);
    cmd_valid_i <= 1'b1;
    cmd_i <= x;
    do begin
      @(posedge core_clk_i);
      k++;
    end while (cmd_ready_o !== 1'b1 && k < 20000);
    cmd_valid_i <= 1'b0;
  endtask

  // notes the expected byte, then issues the read
  task automatic rd_chk(input snp_cmd_t x, input logic [7:0] e);
    exp_q.push_back(e);
    send(x);
  endtask

  // compares every returned read byte with the oldest note
  always @(posedge core_clk_i) begin
    if (rsp_valid_o === 1'b1) begin
      if (exp_q.size() == 0)
        cmp_byte("unexpected read", 8'h00, rsp_data_o);
      else
        cmp_byte("read data", exp_q.pop_front(), rsp_data_o);
    end
  end

  // hang guard
  always @(posedge core_clk_i) begin
    cyc++;
    if (cyc == 40000) begin
      err_count++;
      $display("mismatch run time expected done seen running");
      print_verdict();
    end
  end

  initial begin : main
    snp_cmd_t    c [5];
    logic [13:0] ad, w, ws;
    logic [7:0]  d [6];
    int          acc, k;
    rstn_i = 1'b0;
    cmd_valid_i = 1'b0;
    cmd_i = '0;
    present = 1'b1;
    for (int i = 0; i < 6; i++) d[i] = 8'($random(seed));
    ad = {4'h0, 10'($random(seed))};
    w = {8'($random(seed)), 6'h3F};
    ws = {w[13:6], 6'h00};
    c[0] = mk(CMD_WRITE_EE, 1'b0, ad, d[0]);
    c[1] = mk(CMD_READ_EE, 1'b0, ad, 8'h00);
    c[2] = mk(CMD_WRITE_EE, 1'b0, ad, d[1]);
    c[3] = mk(CMD_READ_EE, 1'b0, ad, 8'h00);
    c[4] = mk(CMD_WRITE_EE, 1'b0, 14'h03FF, d[2]);
    exp_q.push_back(d[0]);
    exp_q.push_back(d[1]);
    repeat (2) @(posedge core_clk_i);
    rstn_i <= 1'b1;
    // fill the queue while the host is still in its power-up wait
    @(posedge core_clk_i);
    cmd_valid_i <= 1'b1;
    cmd_i <= c[0];
    acc = 0;
    repeat (8) begin
      @(posedge core_clk_i);
      if (cmd_ready_o === 1'b1 && acc < 5) begin
        acc++;
        if (acc < 5) cmd_i <= c[acc];
      end
    end
    cmd_valid_i <= 1'b0;
    cmp_byte("commands taken", 8'h04, 8'(acc));
    cmp_flag("queue ready", 1'b0, cmd_ready_o);
    send(c[4]);
    rd_chk(mk(CMD_READ_EE, 1'b0, 14'h03FF, 8'h00), d[2]);
    cmp_flag("in session", 1'b1, in_prog_o);
    $display("test eeprom done");
    send(mk(CMD_ERASE, 1'b0, 14'h0000, 8'h00));
    rd_chk(mk(CMD_READ_EE, 1'b0, ad, 8'h00), 8'hFF);
    rd_chk(mk(CMD_READ_PM, 1'b1, w, 8'h00), 8'hFF);
    send(mk(CMD_LOAD, 1'b0, w, d[3]));
    send(mk(CMD_LOAD, 1'b1, w, d[4]));
    send(mk(CMD_LOAD, 1'b0, ws, d[5]));
    send(mk(CMD_WRITE_PAGE, 1'b0, w, 8'h00));
    rd_chk(mk(CMD_READ_PM, 1'b0, w, 8'h00), d[3]);
    rd_chk(mk(CMD_READ_PM, 1'b1, w, 8'h00), d[4]);
    rd_chk(mk(CMD_READ_PM, 1'b0, ws, 8'h00), d[5]);
    $display("test erase and flash done");
    send(mk(CMD_END, 1'b0, 14'h0000, 8'h00));
    k = 0;
    while (dev_rst_n_o !== 1'b1 && k < 20000) begin
      @(posedge core_clk_i);
      k++;
    end
    @(posedge core_clk_i);
    cmp_flag("target reset", 1'b1, dev_rst_n_o);
    cmp_flag("session", 1'b0, in_prog_o);
    cmp_byte("reads left", 8'h00, 8'(exp_q.size()));
    $display("test end done");
    present <= 1'b0;
    send(mk(CMD_WRITE_EE, 1'b0, ad, d[0]));
    k = 0;
    while (no_device_o !== 1'b1 && k < 15000) begin
      @(posedge core_clk_i);
      k++;
    end
    cmp_flag("no device", 1'b1, no_device_o);
    cmp_flag("session", 1'b0, in_prog_o);
    $display("test no device done");
    print_verdict();
  end
endmodule
